// [core/ric_top.sv]
// restart interlock control: channel select, config decode, reset timing, safety outputs, APB slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ric_top #(
   parameter logic [32:0] MIN_PRESS_CYC = 33'(ric_pkg::MIN_CYC),
   parameter logic [32:0] MAX_PRESS_CYC = 33'(ric_pkg::MAX_CYC),
   parameter logic [32:0] FAULT_CYC     = 33'(ric_pkg::FAULT_CYC),
   parameter logic [32:0] SELFTEST_CYC  = 33'(ric_pkg::SELF_CYC),
   parameter logic [32:0] SHOWRT_CYC    = 33'(ric_pkg::SHOW_CYC),
   parameter logic [3:0]  RESP_DIGIT    = 4'h5
) (
   input  wire logic        CLK_I,
   input  wire logic        RESETN_I,
   input  wire logic        APB_PSEL_I,
   input  wire logic        APB_PENABLE_I,
   input  wire logic        APB_PWRITE_I,
   input  wire logic [7:0]  APB_PADDR_I,
   input  wire logic [31:0] APB_PWDATA_I,
   output logic [31:0]      APB_PRDATA_O,
   output logic             APB_PREADY_O,
   output logic             APB_PSLVERR_O,
   output logic             IRQ_O,
   input  wire logic        RESET_IN_LAMP_OUT_PIN_I,
   output logic             RESET_IN_LAMP_OUT_PIN_O,
   output logic             RESET_IN_LAMP_OUT_PIN_OE_O,
   input  wire logic        CONTACTOR_FEEDBACK_HI_I,
   input  wire logic        CONTACTOR_FEEDBACK_LO_I,
   input  wire logic        INTERLOCK_SELECT_INPUT_I,
   input  wire logic        SUPPLY_PIN_A_I,
   input  wire logic        SUPPLY_PIN_B_I,
   input  wire logic        FIELD_CLEAR_I,
   input  wire logic        RECEPTION_MARGINAL_I,
   output logic             SAFETY_OUTPUT_A_O,
   output logic             SAFETY_OUTPUT_B_O,
   output logic             MAIN_IND_GREEN_O,
   output logic             MAIN_IND_RED_O,
   output logic             READY_IND_YELLOW_O,
   output logic [6:0]       SEGMENTS_O,
   output logic [1:0]       CHANNEL_O
);

   function automatic logic [6:0] ric_seg7(input logic [3:0] d);
      logic [6:0] s;
      s = ric_pkg::SEG_BAR;
      case (d)
         4'h0: s = 7'h3f;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5b;
         4'h3: s = 7'h4f;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6d;
         4'h6: s = 7'h7d;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h6f;
         default: s = ric_pkg::SEG_BAR;
      endcase
      return s;
   endfunction

   // ---------------- pin synchroniser: three flops, change taken once stages two and three agree
   ric_pkg::ric_pins_t pins_raw;
   ric_pkg::ric_pins_t pins_m1;
   ric_pkg::ric_pins_t pins_m2;
   ric_pkg::ric_pins_t pins_m3;
   ric_pkg::ric_pins_t pins;
   ric_pkg::ric_pins_t next_pins;

   assign pins_raw  = '{rst_btn: RESET_IN_LAMP_OUT_PIN_I, fb_hi: CONTACTOR_FEEDBACK_HI_I,
                        fb_lo: CONTACTOR_FEEDBACK_LO_I, sel: INTERLOCK_SELECT_INPUT_I,
                        sup_a: SUPPLY_PIN_A_I, sup_b: SUPPLY_PIN_B_I};
   assign next_pins = (pins_m2 & ~(pins_m2 ^ pins_m3)) | (pins & (pins_m2 ^ pins_m3));

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         pins_m1 <= '0;
         pins_m2 <= '0;
         pins_m3 <= '0;
         pins    <= '0;
      end else begin
         pins_m1 <= pins_raw;
         pins_m2 <= pins_m1;
         pins_m3 <= pins_m2;
         pins    <= next_pins;
      end
   end

   // ---------------- configuration decode
   ric_pkg::ric_edm_t  edm_mode;
   ric_pkg::ric_chan_t chan;
   logic               edm_ok;

   // both comparators high cannot happen on a sound line; treat it as an open loop
   assign edm_mode = (pins.fb_hi && !pins.fb_lo) ? ric_pkg::EDM_OFF :
                     (pins.fb_lo && !pins.fb_hi) ? ric_pkg::EDM_CLOSED :
                     ric_pkg::EDM_OPEN;
   assign edm_ok   = (edm_mode != ric_pkg::EDM_OPEN);
   assign chan     = (pins.sup_a && !pins.sup_b) ? ric_pkg::CH_ONE :
                     (!pins.sup_a && pins.sup_b) ? ric_pkg::CH_TWO :
                     ric_pkg::CH_NONE;

   // ---------------- reset button timing
   // the button is a make contact to the supply, so a high level means pressed
   logic              pressed;
   logic              pressed_q;
   logic [32:0]       press_cnt;
   logic              released;
   logic              rel_valid;
   logic              rel_short;
   logic              rel_long;
   logic              hit_max;
   logic              hit_fault;

   assign pressed   = pins.rst_btn;
   assign released  = pressed_q && !pressed;
   assign rel_short = released && (press_cnt < MIN_PRESS_CYC);
   assign rel_long  = released && (press_cnt >= MAX_PRESS_CYC);
   assign rel_valid = released && !rel_short && !rel_long;
   assign hit_max   = pressed && (press_cnt == MAX_PRESS_CYC);
   assign hit_fault = pressed && (press_cnt == FAULT_CYC);

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         pressed_q <= 1'b0;
         press_cnt <= '0;
      end else begin
         pressed_q <= pressed;
         if (!pressed)
            press_cnt <= '0;
         else if (press_cnt < FAULT_CYC)
            press_cnt <= press_cnt + 33'h1;
      end
   end

   // ---------------- operating state
   ric_pkg::ric_state_t state;
   ric_pkg::ric_state_t next_state;
   logic [32:0]         phase_cnt;
   logic                res_en;
   logic                align_en;
   logic                phase_done;

   assign phase_done = (state == ric_pkg::ST_SELFTEST) ? (phase_cnt >= SELFTEST_CYC - 33'h1) :
                       (phase_cnt >= SHOWRT_CYC - 33'h1);

   always_comb begin
      next_state = state;
      case (state)
         ric_pkg::ST_SELFTEST: begin
            if (phase_done)
               next_state = ric_pkg::ST_SHOWRT;
         end
         ric_pkg::ST_SHOWRT: begin
            if (phase_done)
               next_state = ric_pkg::ST_LOCKED;
         end
         ric_pkg::ST_LOCKED: begin
            if (hit_fault)
               next_state = ric_pkg::ST_FAULT;
            else if (FIELD_CLEAR_I && edm_ok && (!res_en || rel_valid))
               next_state = ric_pkg::ST_ON;
         end
         ric_pkg::ST_ON: begin
            if (hit_fault)
               next_state = ric_pkg::ST_FAULT;
            else if (!FIELD_CLEAR_I)
               next_state = ric_pkg::ST_LOCKED;
         end
         ric_pkg::ST_FAULT: begin
            // leaving needs the short to go away; the normal unlock is still required after
            if (!pressed)
               next_state = ric_pkg::ST_LOCKED;
         end
         default: next_state = ric_pkg::ST_SELFTEST;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         state     <= ric_pkg::ST_SELFTEST;
         phase_cnt <= '0;
      end else begin
         state     <= next_state;
         phase_cnt <= (next_state != state) ? 33'h0 : phase_cnt + 33'h1;
      end
   end

   // lockout select: the bridged case can only be told apart while the lamp drives low,
   // which is during the lamp test in self test and while the outputs are on;
   // in ON the lamp falls one cycle late and then crosses the synchroniser, so a fresh
   // ON state waits before it trusts the select level, else a bridged unit could relock
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I)
         res_en <= 1'b1;
      else if ((state == ric_pkg::ST_SELFTEST && phase_done) ||
               (state == ric_pkg::ST_ON && phase_cnt >= ric_pkg::SEL_SETTLE_CYC))
         res_en <= pins.sel;
   end

   // ---------------- outputs
   logic [31:0] blink_cnt;
   logic        blink;
   logic        safety_switching_output;
   logic        align_warn;

   assign blink      = blink_cnt[ric_pkg::BLINK_BIT];
   assign align_warn = align_en && RECEPTION_MARGINAL_I && FIELD_CLEAR_I;

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         blink_cnt                 <= '0;
         safety_switching_output                      <= 1'b0;
         RESET_IN_LAMP_OUT_PIN_O   <= 1'b0;
         MAIN_IND_GREEN_O          <= 1'b0;
         MAIN_IND_RED_O            <= 1'b0;
         READY_IND_YELLOW_O        <= 1'b0;
         SEGMENTS_O                <= '0;
         CHANNEL_O                 <= ric_pkg::CH_NONE;
      end else begin
         blink_cnt <= blink_cnt + 32'h1;
         // one flop feeds both output pins so they cannot part
         safety_switching_output <= (state == ric_pkg::ST_ON) && FIELD_CLEAR_I;
         RESET_IN_LAMP_OUT_PIN_O <= (state == ric_pkg::ST_SELFTEST) ? 1'b0 :
                                    !((state == ric_pkg::ST_ON) && FIELD_CLEAR_I);
         MAIN_IND_GREEN_O   <= (state == ric_pkg::ST_ON) && (!align_warn || blink);
         MAIN_IND_RED_O     <= (state == ric_pkg::ST_LOCKED) || (state == ric_pkg::ST_FAULT);
         READY_IND_YELLOW_O <= (state == ric_pkg::ST_LOCKED) && FIELD_CLEAR_I && res_en;
         if (state == ric_pkg::ST_SHOWRT)
            SEGMENTS_O <= ric_seg7(RESP_DIGIT);
         else if (state == ric_pkg::ST_ON && align_warn)
            SEGMENTS_O <= blink ? ric_pkg::SEG_ALL : 7'h00;
         else if (state == ric_pkg::ST_SELFTEST)
            SEGMENTS_O <= ric_pkg::SEG_ALL;
         else
            SEGMENTS_O <= ric_pkg::SEG_BAR;
         CHANNEL_O <= chan;
      end
   end

   assign SAFETY_OUTPUT_A_O          = safety_switching_output;
   assign SAFETY_OUTPUT_B_O          = safety_switching_output;
   assign RESET_IN_LAMP_OUT_PIN_OE_O = 1'b1;

   // ---------------- APB slave, zero wait states
   logic [ric_pkg::IRQ_W-1:0] irq_stat;
   logic [ric_pkg::IRQ_W-1:0] irq_mask;
   logic [ric_pkg::IRQ_W-1:0] irq_ev;
   logic                      hit_ctrl;
   logic                      hit_stat;
   logic                      hit_istat;
   logic                      hit_imask;
   logic                      mapped;
   logic                      setup;
   logic                      access;
   logic [31:0]               rd_mux;
   logic [31:0]               stat_word;

   assign setup  = APB_PSEL_I && !APB_PENABLE_I;
   assign access = APB_PSEL_I && APB_PENABLE_I;
   assign hit_ctrl  = (APB_PADDR_I == ric_pkg::OFS_CTRL);
   assign hit_stat  = (APB_PADDR_I == ric_pkg::OFS_STAT);
   assign hit_istat = (APB_PADDR_I == ric_pkg::OFS_ISTAT);
   assign hit_imask = (APB_PADDR_I == ric_pkg::OFS_IMASK);
   assign mapped    = hit_ctrl || hit_stat || hit_istat || hit_imask;

   assign stat_word = {22'h0, safety_switching_output, FIELD_CLEAR_I, chan, edm_mode, res_en, state};

   always_comb begin
      if (hit_ctrl)
         rd_mux = {31'h0, align_en};
      else if (hit_stat)
         rd_mux = stat_word;
      else if (hit_istat)
         rd_mux = {27'h0, irq_stat};
      else if (hit_imask)
         rd_mux = {27'h0, irq_mask};
      else
         rd_mux = 32'h0;
   end

   assign APB_PREADY_O  = 1'b1;
   assign APB_PSLVERR_O = access && !mapped;
   assign IRQ_O         = |(irq_stat & irq_mask);

   assign irq_ev[ric_pkg::IRQ_UNLOCK] = (state == ric_pkg::ST_LOCKED) && (next_state == ric_pkg::ST_ON);
   assign irq_ev[ric_pkg::IRQ_TRIP]   = (state == ric_pkg::ST_ON) && (next_state == ric_pkg::ST_LOCKED);
   assign irq_ev[ric_pkg::IRQ_IGNORE] = hit_max;
   assign irq_ev[ric_pkg::IRQ_FAULT]  = hit_fault;
   assign irq_ev[ric_pkg::IRQ_SHORT]  = rel_short;

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         APB_PRDATA_O <= '0;
         align_en     <= 1'b0;
         irq_mask     <= ric_pkg::IMASK_RST;
         irq_stat     <= '0;
      end else begin
         // read data is captured in the setup cycle so it comes from a flop at the access edge
         if (setup && !APB_PWRITE_I)
            APB_PRDATA_O <= rd_mux;
         if (access && APB_PWRITE_I && hit_ctrl)
            align_en <= APB_PWDATA_I[ric_pkg::CTRL_ALIGN];
         if (access && APB_PWRITE_I && hit_imask)
            irq_mask <= APB_PWDATA_I[ric_pkg::IRQ_W-1:0];
         // an event in the clearing cycle survives the clear, and so does one that came
         // after the setup edge, as only the bits returned to the reader are cleared
         if (access && !APB_PWRITE_I && hit_istat)
            irq_stat <= (irq_stat & ~APB_PRDATA_O[ric_pkg::IRQ_W-1:0]) | irq_ev;
         else
            irq_stat <= irq_stat | irq_ev;
      end
   end

   // ---------------- checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   chk_outputs_paired: assert property (SAFETY_OUTPUT_A_O == SAFETY_OUTPUT_B_O &&
                       SAFETY_OUTPUT_A_O == ($past(state) == ric_pkg::ST_ON && $past(FIELD_CLEAR_I)))
      else $error("safety outputs differ or disagree with state");
   chk_lamp_inverse: assert property ((state != ric_pkg::ST_SELFTEST) &&
                     $past(state) != ric_pkg::ST_SELFTEST |-> RESET_IN_LAMP_OUT_PIN_O == !safety_switching_output)
      else $error("lamp not inverse of safety output");
   chk_red_locked: assert property (state == ric_pkg::ST_LOCKED |=> MAIN_IND_RED_O && !safety_switching_output)
      else $error("locked without red or with outputs on");
   chk_short_ignored: assert property (state == ric_pkg::ST_LOCKED && res_en && rel_short
                      |=> state != ric_pkg::ST_ON)
      else $error("short press unlocked");
   chk_valid_unlock: assert property (state == ric_pkg::ST_LOCKED && res_en && rel_valid && FIELD_CLEAR_I
                     && edm_ok && !hit_fault |=> state == ric_pkg::ST_ON ##1 safety_switching_output == $past(FIELD_CLEAR_I))
      else $error("valid press did not unlock");
   chk_long_ignored: assert property (state == ric_pkg::ST_LOCKED && res_en && rel_long
                     |=> state != ric_pkg::ST_ON)
      else $error("long press unlocked");
   chk_fault_entry: assert property (hit_fault && (state == ric_pkg::ST_LOCKED || state == ric_pkg::ST_ON)
                    |=> state == ric_pkg::ST_FAULT ##1 !safety_switching_output)
      else $error("held press did not fault");
   chk_trip_off: assert property (state == ric_pkg::ST_ON && !FIELD_CLEAR_I && !hit_fault
                 |=> state == ric_pkg::ST_LOCKED ##1 !SAFETY_OUTPUT_A_O)
      else $error("field break did not lock");
   chk_yellow_ready: assert property (state == ric_pkg::ST_LOCKED && FIELD_CLEAR_I && res_en
                     |=> READY_IND_YELLOW_O)
      else $error("yellow not lit when ready");
   chk_showrt_digit: assert property (state == ric_pkg::ST_SHOWRT
                     |=> SEGMENTS_O == ric_seg7(RESP_DIGIT))
      else $error("response time not shown");
   chk_green_steady: assert property (state == ric_pkg::ST_ON && FIELD_CLEAR_I && !align_warn
                     |=> MAIN_IND_GREEN_O && safety_switching_output)
      else $error("clear field in ON without steady green and outputs");
   chk_flash_dark: assert property (state == ric_pkg::ST_ON && align_warn && !blink
                   |=> !MAIN_IND_GREEN_O && SEGMENTS_O == 7'h00)
      else $error("marginal reception not flashed");
   chk_bridge_stays_off: assert property (state == ric_pkg::ST_ON && !res_en
                         |=> !res_en)
      else $error("bridged select re-enabled the lockout");
   chk_channel_pick: assert property ($stable(pins) && pins.sup_a && !pins.sup_b |=> CHANNEL_O == ric_pkg::CH_ONE)
      else $error("channel one not selected");

endmodule
`default_nettype wire

// [pkg/ric_pkg.sv]
// package: shared types, register map and timing constants of the restart interlock control
package ric_pkg;

   // state codes run Gray along the usual path selftest -> show -> locked <-> on
   typedef enum logic [2:0] {
      ST_SELFTEST = 3'h0,
      ST_SHOWRT   = 3'h1,
      ST_LOCKED   = 3'h3,
      ST_ON       = 3'h2,
      ST_FAULT    = 3'h6
   } ric_state_t;

   typedef enum logic [1:0] {
      EDM_OFF    = 2'h0,
      EDM_CLOSED = 2'h1,
      EDM_OPEN   = 2'h2
   } ric_edm_t;

   typedef enum logic [1:0] {
      CH_NONE = 2'h0,
      CH_ONE  = 2'h1,
      CH_TWO  = 2'h2
   } ric_chan_t;

   // pin levels as seen by the comparators, carried together through the synchroniser
   typedef struct packed {
      logic rst_btn;
      logic fb_hi;
      logic fb_lo;
      logic sel;
      logic sup_a;
      logic sup_b;
   } ric_pins_t;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_STAT  = 8'h04;
   localparam logic [7:0] OFS_ISTAT = 8'h08;
   localparam logic [7:0] OFS_IMASK = 8'h0c;

   // control and status field positions
   localparam int CTRL_ALIGN   = 0;
   localparam int STAT_RES     = 3;
   localparam int STAT_FIELD   = 8;
   localparam int STAT_SAFETY_SWITCHING_OUTPUT    = 9;

   // interrupt event bits
   localparam int IRQ_W        = 5;
   localparam int IRQ_UNLOCK   = 0;
   localparam int IRQ_TRIP     = 1;
   localparam int IRQ_IGNORE   = 2;
   localparam int IRQ_FAULT    = 3;
   localparam int IRQ_SHORT    = 4;
   localparam logic [IRQ_W-1:0] IMASK_RST = 5'h00;

   // timing: figures in ms, counts derived from the clock rate
   localparam longint unsigned CLK_HZ      = 200_000_000;
   localparam longint unsigned T_MIN_MS    = 150;
   localparam longint unsigned T_MAX_MS    = 4000;
   localparam longint unsigned T_FAULT_MS  = 30000;
   localparam longint unsigned T_SELF_MS   = 10;
   localparam longint unsigned T_SHOW_MS   = 1000;
   localparam int              CNT_W       = 33;
   // cycles in ON before the select level reflects the low lamp through the synchroniser
   localparam logic [CNT_W-1:0] SEL_SETTLE_CYC = 33'h8;
   // the maximum press time rounds down, all other times round up
   localparam longint unsigned MIN_CYC   = (T_MIN_MS * CLK_HZ + 999) / 1000;
   localparam longint unsigned MAX_CYC   = (T_MAX_MS * CLK_HZ) / 1000;
   localparam longint unsigned FAULT_CYC = (T_FAULT_MS * CLK_HZ + 999) / 1000;
   localparam longint unsigned SELF_CYC  = (T_SELF_MS * CLK_HZ + 999) / 1000;
   localparam longint unsigned SHOW_CYC  = (T_SHOW_MS * CLK_HZ + 999) / 1000;

   localparam int BLINK_BIT = 25;
   localparam logic [6:0] SEG_ALL  = 7'h7f;
   localparam logic [6:0] SEG_BAR  = 7'h40;

endpackage

// [tb/ric_partner.sv]
// behavioural far side: reset button, contactor feedback, select bridge and supply polarity
`timescale 1ns/1ps
`default_nettype none
module ric_partner (
   input  wire logic       press_i,
   input  wire logic       bridge_i,
   input  wire logic [1:0] fb_mode_i,
   input  wire logic       swap_i,
   input  wire logic       lamp_i,
   input  wire logic       lamp_oe_i,
   output logic            btn_o,
   output logic            fb_hi_o,
   output logic            fb_lo_o,
   output logic            sel_o,
   output logic            sup_a_o,
   output logic            sup_b_o
);
   // normally-open contact reaches the positive rail only while actuated
   assign btn_o   = press_i;
   // mode 0 ties the loop to the rail, 1 closes it to ground, 2 floats it so neither comparator trips
   assign fb_hi_o = (fb_mode_i == 2'h0);
   assign fb_lo_o = (fb_mode_i == 2'h1);
   // a bridged select follows the lamp; an undriven lamp line is taken as low
   assign sel_o   = bridge_i ? (lamp_oe_i & lamp_i) : 1'b1;
   assign sup_a_o = ~swap_i;
   assign sup_b_o = swap_i;
endmodule
`default_nettype wire

// [tb/test_restart_interlock_control.sv]
// self-checking bench for the restart interlock control
`timescale 1ns/1ps
`default_nettype none
module test_restart_interlock_control;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic               field = 1'b1;
   logic               marg = 1'b0;
   logic               press = 1'b0;
   logic               bridge = 1'b0;
   logic               swap = 1'b0;
   logic [1:0]         fb_mode = 2'h1;
   logic [31:0]        rd;
   logic [31:0]        v;
   logic               err;
   ric_pkg::ric_chan_t ch;
   int                 n_fail = 0;
   int                 samples_checked = 0;
   wire logic [31:0]   prdata;
   wire logic          pready, pslverr, irq, lamp, lamp_oe, btn, fb_hi, fb_lo, sel, sup_a, sup_b;
   wire logic          out_a, out_b, green, red, yellow;
   wire logic [6:0]    seg;
   wire logic [1:0]    chan;

   always #2.5 clk = ~clk;

   ric_top #(.MIN_PRESS_CYC(33'h14), .MAX_PRESS_CYC(33'h3c), .FAULT_CYC(33'hc8),
             .SELFTEST_CYC(33'h8), .SHOWRT_CYC(33'h8)) i_dut (
      .CLK_I(clk), .RESETN_I(rst_n), .APB_PSEL_I(psel), .APB_PENABLE_I(penable),
      .APB_PWRITE_I(pwrite), .APB_PADDR_I(paddr), .APB_PWDATA_I(pwdata), .APB_PRDATA_O(prdata),
      .APB_PREADY_O(pready), .APB_PSLVERR_O(pslverr), .IRQ_O(irq),
      .RESET_IN_LAMP_OUT_PIN_I(btn), .RESET_IN_LAMP_OUT_PIN_O(lamp), .RESET_IN_LAMP_OUT_PIN_OE_O(lamp_oe),
      .CONTACTOR_FEEDBACK_HI_I(fb_hi), .CONTACTOR_FEEDBACK_LO_I(fb_lo), .INTERLOCK_SELECT_INPUT_I(sel),
      .SUPPLY_PIN_A_I(sup_a), .SUPPLY_PIN_B_I(sup_b), .FIELD_CLEAR_I(field),
      .RECEPTION_MARGINAL_I(marg), .SAFETY_OUTPUT_A_O(out_a), .SAFETY_OUTPUT_B_O(out_b),
      .MAIN_IND_GREEN_O(green), .MAIN_IND_RED_O(red), .READY_IND_YELLOW_O(yellow),
      .SEGMENTS_O(seg), .CHANNEL_O(chan));

   ric_partner i_far (.press_i(press), .bridge_i(bridge), .fb_mode_i(fb_mode), .swap_i(swap),
      .lamp_i(lamp), .lamp_oe_i(lamp_oe), .btn_o(btn), .fb_hi_o(fb_hi), .fb_lo_o(fb_lo),
      .sel_o(sel), .sup_a_o(sup_a), .sup_b_o(sup_b));

   function automatic logic [31:0] stat_w(ric_pkg::ric_state_t s, logic res, ric_pkg::ric_edm_t e,
                                          ric_pkg::ric_chan_t c, logic f, logic o);
      stat_w = 32'h0;
      stat_w[2:0] = s;
      stat_w[ric_pkg::STAT_RES] = res;
      stat_w[5:4] = e;
      stat_w[7:6] = c;
      stat_w[ric_pkg::STAT_FIELD] = f;
      stat_w[ric_pkg::STAT_SAFETY_SWITCHING_OUTPUT] = o;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // the slave sets the pace: wait for pready, bounded so a dead bus cannot hang the run
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      if (k >= 50) n_fail++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask

   task automatic push(input int n);
      press <= 1'b1;
      repeat (n) @(posedge clk);
      press <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   task automatic outs(input logic on);
      chk(32'(out_a), 32'(on), "output a");
      chk(32'(out_b), 32'(on), "output b");
      chk(32'(red), 32'(!on), "red");
      chk(32'(lamp), 32'(!on), "lamp");
      chk(32'(lamp_oe), 32'h1, "lamp driven");
      chk(32'(green), 32'(on), "green");
   endtask

   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic note(input string s);
      $display("test %s done", s);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end

   initial begin
      void'($urandom(32));
      do_reset;
      repeat (3) @(posedge clk);
      chk(32'(seg), 32'(ric_pkg::SEG_ALL), "selftest segments");
      repeat (8) @(posedge clk);
      // digit 5 lights segments a c d f g
      chk(32'(seg), 32'h6d, "response time shown");
      repeat (17) @(posedge clk);
      outs(1'b0);
      chk(32'(yellow), 32'h1, "yellow ready");
      apb(1'b1, ric_pkg::OFS_IMASK, 32'h10);
      rchk(ric_pkg::OFS_IMASK, 32'h10, "mask");
      note("startup");
      for (int i = 0; i < 3; i++) begin
         fb_mode <= 2'(i);
         swap <= (i == 1);
         ch = (i == 1) ? ric_pkg::CH_TWO : ric_pkg::CH_ONE;
         repeat (8) @(posedge clk);
         chk(32'(chan), 32'(ch), "channel pins");
         rchk(ric_pkg::OFS_STAT, stat_w(ric_pkg::ST_LOCKED, 1'b1, ric_pkg::ric_edm_t'(i), ch, 1'b1, 1'b0),
              "decode");
      end
      fb_mode <= 2'h1;
      swap <= 1'b0;
      repeat (8) @(posedge clk);
      note("decode");
      push($urandom_range(12, 3));
      outs(1'b0);
      chk(32'(irq), 32'h1, "irq short");
      rchk(ric_pkg::OFS_ISTAT, 32'h10, "istat short");
      @(posedge clk);
      chk(32'(irq), 32'h0, "irq cleared");
      push($urandom_range(52, 28));
      outs(1'b1);
      chk(32'(yellow), 32'h0, "yellow on");
      chk(32'(irq), 32'h0, "irq masked");
      rchk(ric_pkg::OFS_STAT, stat_w(ric_pkg::ST_ON, 1'b1, ric_pkg::EDM_CLOSED, ric_pkg::CH_ONE, 1'b1, 1'b1),
           "status on");
      rchk(ric_pkg::OFS_ISTAT, 32'h01, "istat unlock");
      note("unlock");
      field <= 1'b0;
      repeat (4) @(posedge clk);
      outs(1'b0);
      chk(32'(yellow), 32'h0, "yellow blocked");
      field <= 1'b1;
      repeat (10) @(posedge clk);
      outs(1'b0);
      chk(32'(yellow), 32'h1, "yellow again");
      rchk(ric_pkg::OFS_ISTAT, 32'h02, "istat trip");
      push($urandom_range(100, 68));
      outs(1'b0);
      rchk(ric_pkg::OFS_ISTAT, 32'h04, "istat long");
      note("trip and long press");
      press <= 1'b1;
      repeat (215) @(posedge clk);
      rchk(ric_pkg::OFS_STAT, stat_w(ric_pkg::ST_FAULT, 1'b1, ric_pkg::EDM_CLOSED, ric_pkg::CH_ONE, 1'b1, 1'b0),
           "fault");
      press <= 1'b0;
      repeat (10) @(posedge clk);
      rchk(ric_pkg::OFS_STAT, stat_w(ric_pkg::ST_LOCKED, 1'b1, ric_pkg::EDM_CLOSED, ric_pkg::CH_ONE, 1'b1, 1'b0),
           "fault left");
      rchk(ric_pkg::OFS_ISTAT, 32'h0c, "istat fault");
      push($urandom_range(52, 28));
      outs(1'b1);
      note("fault");
      v = $urandom;
      apb(1'b1, ric_pkg::OFS_CTRL, v);
      rchk(ric_pkg::OFS_CTRL, {31'h0, v[0]}, "ctrl");
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0, "unmapped data");
      chk(32'(err), 32'h1, "unmapped error");
      note("registers");
      apb(1'b1, ric_pkg::OFS_CTRL, 32'h1);
      marg <= 1'b1;
      repeat (3) @(posedge clk);
      // the blink counter stays in its dark half far longer than this run lasts
      chk(32'(green), 32'h0, "green flashing");
      chk(32'(seg), 32'h00, "segments flashing");
      apb(1'b1, ric_pkg::OFS_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      outs(1'b1);
      chk(32'(seg), 32'(ric_pkg::SEG_BAR), "segments steady");
      marg <= 1'b0;
      note("alignment");
      // a fresh start lets self test sample the bridged select, so the unit reaches ON with no press
      bridge <= 1'b1;
      do_reset;
      repeat (40) @(posedge clk);
      outs(1'b1);
      chk(32'(yellow), 32'h0, "yellow no lockout");
      rchk(ric_pkg::OFS_STAT, stat_w(ric_pkg::ST_ON, 1'b0, ric_pkg::EDM_CLOSED, ric_pkg::CH_ONE, 1'b1, 1'b1),
           "status bridged");
      field <= 1'b0;
      repeat (4) @(posedge clk);
      outs(1'b0);
      field <= 1'b1;
      repeat (10) @(posedge clk);
      outs(1'b1);
      field <= 1'b0;
      repeat (4) @(posedge clk);
      field <= 1'b1;
      repeat (10) @(posedge clk);
      outs(1'b1);
      rchk(ric_pkg::OFS_STAT, stat_w(ric_pkg::ST_ON, 1'b0, ric_pkg::EDM_CLOSED, ric_pkg::CH_ONE, 1'b1, 1'b1),
           "bridged again");
      note("bridged");
      tally_and_finish;
   end
endmodule
`default_nettype wire
